// ---- verilog/cia_defs.svh ----
// Purpose: constants for the cutter interlock and air control block
// Assumes: 10 MHz clk_sys, AXI4-Lite with 32-bit data
// Notes: byte offsets of the register words
`ifndef CIA_DEFS_SVH
`define CIA_DEFS_SVH
`define CIA_ADDR_W 5
`define CIA_OFF_CTRL 5'h00
`define CIA_OFF_TARGET 5'h04
`define CIA_OFF_LIMITS 5'h08
`define CIA_OFF_STATUS 5'h0c
`define CIA_OFF_STEP 5'h10
`define CIA_POS_W 16
`define CIA_STEP_W 8
`define CIA_DEB_US 5
`define CIA_CLK_MHZ 10
`define CIA_DEB_CYC ((`CIA_DEB_US * `CIA_CLK_MHZ))
`define CIA_CTRL_AUTO 0
`define CIA_CTRL_AIR 1
`define CIA_CTRL_AAC 2
`define CIA_CTRL_PUSH 3
`define CIA_CTRL_REV 4
`define CIA_CTRL_CAL 5
`define CIA_CTRL_MOVE 6
`define CIA_CTRL_DRIVE 7
`define CIA_CTRL_NEWSTEP 8
`define CIA_CTRL_WDOG 9
`define CIA_NIN 8
`define CIA_RESP_OKAY 2'b00
`define CIA_RESP_SLVERR 2'b10
`endif

// ---- verilog/cia_pkg.sv ----
// Purpose: types for the cutter interlock and air control block
// Assumes: nothing beyond the defs header
// Notes: fault classes only
package cia_pkg;
    typedef enum logic [1:0] {cia_ok, cia_minor, cia_major} cia_fault_type;
endpackage

// ---- verilog/cia_top.sv ----
// Purpose: interlock, air and fault control of a cutter backgauge
// Assumes: raw pins asynchronous, keypad gives one level for any key
// Notes: registers over AXI4-Lite, no interrupt
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "cia_defs.svh"
module cia_top
    import cia_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic pin_clamp_down,
    input wire logic pin_knife_down,
    input wire logic pin_false_clamp,
    input wire logic pin_pos_covered,
    input wire logic pin_handwheel,
    input wire logic pin_curtain,
    input wire logic pin_any_key,
    input wire logic pin_spare,
    input wire logic [`CIA_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`CIA_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic motor_enable,
    output logic auto_correct,
    output logic air_motor,
    output logic air_solenoid,
    output logic load_enable,
    output logic cut_enable,
    output logic step_advance
);

////////////////////////////////////////////////////////////////////////////
// input conditioning
logic [`CIA_NIN-1:0] raw_in, sync1, sync2, deb;
assign raw_in = {pin_spare, pin_any_key, pin_curtain, pin_handwheel,
    pin_pos_covered, pin_false_clamp, pin_knife_down, pin_clamp_down};

always_ff @(posedge clk_sys)
begin
    sync1 <= raw_in;
    sync2 <= sync1;
end
// a level must hold the whole window to count, so contact bounce is lost
genvar gi;
generate
    for (gi = 0; gi < `CIA_NIN; gi++)
    begin : g_deb
        logic [7:0] cnt;
        logic [7:0] next_cnt;
        logic next_deb;
        always_comb
        begin
            next_cnt = 8'h00;
            next_deb = deb[gi];
            if (sync2[gi] != deb[gi])
            begin
                next_cnt = cnt + 8'h01;
                if (cnt == 8'(`CIA_DEB_CYC - 1))
                begin
                    next_deb = sync2[gi];
                    next_cnt = 8'h00;
                end
            end
        end
        always_ff @(posedge clk_sys)
        begin
            if (sys_rst)
            begin
                cnt <= 8'h00;
                deb[gi] <= 1'b0;
            end
            else
            begin
                cnt <= next_cnt;
                deb[gi] <= next_deb;
            end
        end
    end
endgenerate
logic clamp_dn, knife_dn, fclamp, pos_cov, hwheel, curtain, key;
assign {key, curtain, hwheel, pos_cov, fclamp, knife_dn, clamp_dn} =
    deb[6:0];

////////////////////////////////////////////////////////////////////////////
// register file and AXI4-Lite slave
logic [9:0] ctrl;
logic [`CIA_POS_W-1:0] target, tbl_min, tbl_max, fc_size;
logic [`CIA_STEP_W-1:0] step;
logic [31:0] status_word;
logic aw_held, w_held, tgt_wr;
logic [`CIA_ADDR_W-1:0] aw_addr;
logic [31:0] w_data;
logic [3:0] w_strb;
logic [9:0] next_ctrl;
logic [`CIA_POS_W-1:0] next_target, next_tbl_min, next_tbl_max, next_fc_size;
logic [31:0] wmask;
logic do_write;
logic step_inc;

assign do_write = aw_held && w_held && !s_axi_bvalid;
assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
    {8{w_strb[1]}}, {8{w_strb[0]}}};
function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
endfunction
always_comb
begin
    next_ctrl = ctrl;
    next_target = target;
    next_tbl_min = tbl_min;
    next_tbl_max = tbl_max;
    next_fc_size = fc_size;
    // command bits are one-shot and self-clear
    next_ctrl[`CIA_CTRL_MOVE] = 1'b0;
    next_ctrl[`CIA_CTRL_NEWSTEP] = 1'b0;
    next_ctrl[`CIA_CTRL_WDOG] = 1'b0;
    if (step_inc)
        next_ctrl[`CIA_CTRL_AAC] = 1'b0;
    if (do_write)
    begin
        unique case (aw_addr)
            `CIA_OFF_CTRL:
            begin
                next_ctrl = 10'(merge({22'h0, ctrl}, w_data, wmask));
                if (next_ctrl[`CIA_CTRL_NEWSTEP])
                    next_ctrl[`CIA_CTRL_AAC] = 1'b0;
            end
            `CIA_OFF_TARGET:
                next_target = 16'(merge({16'h0, target}, w_data, wmask));
            `CIA_OFF_LIMITS:
                {next_tbl_max, next_tbl_min} =
                    merge({tbl_max, tbl_min}, w_data, wmask);
            `CIA_OFF_STEP:
                next_fc_size = 16'(merge({16'h0, fc_size}, w_data, wmask));
            default:
                next_target = target;
        endcase
    end
end
logic wr_ok, rd_ok;
assign wr_ok = (aw_addr == `CIA_OFF_CTRL) || (aw_addr == `CIA_OFF_TARGET)
    || (aw_addr == `CIA_OFF_LIMITS) || (aw_addr == `CIA_OFF_STEP);
assign rd_ok = (s_axi_araddr <= `CIA_OFF_STEP) && (s_axi_araddr[1:0] == 2'b00);

always_ff @(posedge clk_sys)
begin
    if (sys_rst)
    begin
        ctrl <= 10'h000;
        target <= 16'h0000;
        tbl_min <= 16'h0000;
        tbl_max <= 16'hffff;
        fc_size <= 16'h0000;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= 5'h00;
        w_data <= 32'h0;
        w_strb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `CIA_RESP_OKAY;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `CIA_RESP_OKAY;
        tgt_wr <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_arready <= 1'b1;
    end
    else
    begin
        ctrl <= next_ctrl;
        target <= next_target;
        tbl_min <= next_tbl_min;
        tbl_max <= next_tbl_max;
        fc_size <= next_fc_size;
        tgt_wr <= do_write && (aw_addr == `CIA_OFF_TARGET);
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (do_write)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `CIA_RESP_OKAY : `CIA_RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
            s_axi_rresp <= rd_ok ? `CIA_RESP_OKAY : `CIA_RESP_SLVERR;
            unique case (s_axi_araddr)
                `CIA_OFF_CTRL: s_axi_rdata <= {22'h0, ctrl};
                `CIA_OFF_TARGET: s_axi_rdata <= {16'h0, target};
                `CIA_OFF_LIMITS: s_axi_rdata <= {tbl_max, tbl_min};
                `CIA_OFF_STATUS: s_axi_rdata <= status_word;
                `CIA_OFF_STEP: s_axi_rdata <= {8'h0, step, fc_size};
                default: s_axi_rdata <= 32'h0;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end
////////////////////////////////////////////////////////////////////////////
// sequencing, interlock, air and faults
cia_fault_type fault, next_fault;
logic powered, next_powered;
logic clamp_seen, next_clamp_seen;
logic hw_prev, key_prev, knife_prev;
logic next_auto_correct, next_air, range_bad, fc_bad;
logic key_edge;
logic [`CIA_STEP_W-1:0] next_step;
logic [`CIA_POS_W-1:0] min_lim;

assign key_edge = key && !key_prev;
assign min_lim = fclamp ? ((fc_size > tbl_min) ? fc_size : tbl_min)
    : tbl_min;
assign range_bad = (target < tbl_min) || (target > tbl_max);
assign fc_bad = fclamp && (target < min_lim);
// a remaining cause re-raises the minor fault at every key release
logic recheck;
assign recheck = (fault == cia_ok) && (range_bad || fc_bad) && key_prev
    && !key;
always_comb
begin
    next_powered = powered || curtain;
    next_clamp_seen = clamp_seen;
    next_step = step;
    step_inc = 1'b0;
    next_fault = fault;
    next_auto_correct = auto_correct;
    if (clamp_dn)
        next_clamp_seen = 1'b1;
    // in auto mode, knife coming down after the clamp went down ends one cut cycle
    if (ctrl[`CIA_CTRL_AUTO] && clamp_seen && knife_dn && !knife_prev)
    begin
        next_step = step + 8'h01;
        step_inc = 1'b1;
        next_clamp_seen = 1'b0;
    end
    if (hw_prev && !hwheel)
        next_auto_correct = 1'b1;
    if (ctrl[`CIA_CTRL_DRIVE] || hwheel)
        next_auto_correct = 1'b0;
    else if (ctrl[`CIA_CTRL_MOVE])
        next_auto_correct = 1'b1;
    // fault evaluation: the set is checked after the clear so it wins
    if (fault == cia_minor && key_edge)
        next_fault = cia_ok;
    if (fault != cia_major && tgt_wr && (range_bad || fc_bad))
        next_fault = cia_minor;
    if (recheck)
        next_fault = cia_minor;
    if (ctrl[`CIA_CTRL_WDOG])
        next_fault = cia_major;
    if (ctrl[`CIA_CTRL_CAL] && key_edge)
        next_fault = cia_major;
    if (fault == cia_major)
        next_fault = cia_major;
    // air path
    if (ctrl[`CIA_CTRL_PUSH] || ctrl[`CIA_CTRL_REV])
        next_air = 1'b1;
    else if (clamp_dn)
        next_air = ctrl[`CIA_CTRL_AUTO] && ctrl[`CIA_CTRL_AAC];
    else
        next_air = ctrl[`CIA_CTRL_AIR];
    if (!next_powered)
        next_air = 1'b0;
end
always_ff @(posedge clk_sys)
begin
    if (sys_rst)
    begin
        fault <= cia_ok;
        powered <= 1'b0;
        clamp_seen <= 1'b0;
        step <= 8'h00;
        hw_prev <= 1'b0;
        key_prev <= 1'b0;
        knife_prev <= 1'b0;
        auto_correct <= 1'b0;
        motor_enable <= 1'b0;
        air_motor <= 1'b0;
        air_solenoid <= 1'b0;
        load_enable <= 1'b0;
        cut_enable <= 1'b1;
        step_advance <= 1'b0;
        status_word <= 32'h0;
    end
    else
    begin
        fault <= next_fault;
        powered <= next_powered;
        clamp_seen <= next_clamp_seen;
        step <= next_step;
        hw_prev <= hwheel;
        key_prev <= key;
        knife_prev <= knife_dn;
        auto_correct <= next_auto_correct;
        step_advance <= step_inc;
        motor_enable <= next_powered && !clamp_dn && !knife_dn
            && fault != cia_major && !fc_bad && !range_bad;
        air_motor <= next_air;
        air_solenoid <= next_air;
        load_enable <= next_powered && fault == cia_ok;
        cut_enable <= !next_powered || fault != cia_major;
        status_word <= {22'h0, fault, powered, hwheel, pos_cov,
            fclamp, knife_dn, clamp_dn, auto_correct, 1'b0};
    end
end

endmodule

// ---- testbench/cia_machine_model.sv ----
// Purpose: sensor and keypad levels seen by cia_top
// Assumes: order clamp knife fclamp pos hwheel curtain key spare
// Notes: spare stays low
`timescale 1ns/1ps
module cia_machine_model
(
    input wire logic clk_sys,
    output logic [7:0] pins
);
    initial pins = 8'h00;
    // switches chatter, so each change bounces before it settles
    task automatic sp(input int i, input logic v);
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clk_sys);
            pins[i] <= v ^ k[0];
        end
        repeat (60) @(negedge clk_sys);
    endtask
endmodule

// ---- testbench/cia_top_asserts.sv ----
// Purpose: port checks for cia_top
// Assumes: debounce settles within 63 cycles
// Notes: raw pins give safe bounds only
`timescale 1ns/1ps
module cia_top_asserts
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic pin_clamp_down,
    input wire logic pin_knife_down,
    input wire logic pin_curtain,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic motor_enable,
    input wire logic air_motor,
    input wire logic air_solenoid,
    input wire logic load_enable,
    input wire logic cut_enable,
    input wire logic step_advance
);
    logic seen_on;
    logic [5:0] down_cnt;
    always_ff @(posedge clk_sys)
        if (sys_rst)
            seen_on <= 1'h0;
        else if (pin_curtain)
            seen_on <= 1'h1;
    // raw level count: one bounce restarts it
    always_ff @(posedge clk_sys)
        if (sys_rst || !(pin_clamp_down || pin_knife_down))
            down_cnt <= 6'h00;
        else if (down_cnt != 6'h3f)
            down_cnt <= down_cnt + 6'h01;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    pwr_hold_a: assert property (!seen_on
        |-> !air_motor && !load_enable)
        else $error("outputs on before curtain");
    cut_pwrup_a: assert property (!seen_on |-> cut_enable)
        else $error("cut enable low in power up");
    air_pair_a: assert property (air_motor == air_solenoid)
        else $error("air outputs differ");
    motor_inhibit_a: assert property (down_cnt == 6'h3f
        |-> !motor_enable)
        else $error("motor on with clamp or knife down");
    rst_out_a: assert property ($fell(sys_rst)
        |-> !motor_enable && cut_enable
        && !step_advance && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs wrong after reset");
    step_pulse_a: assert property (step_advance |=> !step_advance)
        else $error("step pulse too long");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    // both words are held one edge before the response is raised
    wr_answer_a: assert property (wr_both |-> ##2 s_axi_bvalid)
        else $error("no write response");
    rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("no read response");
endmodule
bind cia_top cia_top_asserts chk_u (.clk_sys, .sys_rst, .pin_clamp_down,
    .pin_knife_down, .pin_curtain, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .motor_enable, .air_motor, .air_solenoid, .load_enable,
    .cut_enable, .step_advance);

// ---- testbench/cia_top_tb.sv ----
// Purpose: self-checking bench for cia_top
// Assumes: machine model drives all pins
// Notes: outputs are sampled at the falling edge
`timescale 1ns/1ps
`include "cia_defs.svh"
module cia_top_tb;
    localparam logic [4:0] CT = `CIA_OFF_CTRL, TG = `CIA_OFF_TARGET;
    localparam logic [4:0] LM = `CIA_OFF_LIMITS, ST = `CIA_OFF_STATUS;
    localparam logic [4:0] SP = `CIA_OFF_STEP;
    localparam logic [1:0] OK = `CIA_RESP_OKAY;
    logic clk_sys = 1'h0;
    logic sys_rst = 1'h1;
    logic [7:0] pins;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, motor_enable, auto_correct, air_motor, air_solenoid;
    logic load_enable, cut_enable, step_advance;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int fail_count = 0, cmp_count = 0, cycles = 0;
    int steps = 0;
    cia_machine_model mach_u (.clk_sys, .pins);
    cia_top dut_u (.clk_sys, .sys_rst, .pin_clamp_down(pins[0]),
        .pin_knife_down(pins[1]), .pin_false_clamp(pins[2]),
        .pin_pos_covered(pins[3]), .pin_handwheel(pins[4]),
        .pin_curtain(pins[5]), .pin_any_key(pins[6]), .pin_spare(pins[7]),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .motor_enable, .auto_correct, .air_motor,
        .air_solenoid, .load_enable, .cut_enable, .step_advance);
    initial forever #50 clk_sys = ~clk_sys;
    // the pulse spans a whole cycle, so one falling edge sees it
    always @(negedge clk_sys)
        if (step_advance === 1'h1)
            steps++;
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    function automatic logic [31:0] b(input int n);
        return 32'h1 << n;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic aw, w;
        aw = 1'h1;
        w = 1'h1;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (aw || w)
        begin
            @(negedge clk_sys);
            aw = aw && s_axi_awready !== 1'h1;
            w = w && s_axi_wready !== 1'h1;
            @(posedge clk_sys);
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        do @(negedge clk_sys); while (s_axi_bvalid !== 1'h1);
        chk("bresp", er, s_axi_bresp);
        @(posedge clk_sys);
        s_axi_bready <= 1'h0;
        repeat (3) @(negedge clk_sys);
    endtask
    task automatic rc(input logic [4:0] a, input logic [31:0] m,
        input logic [31:0] e);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(negedge clk_sys); while (s_axi_arready !== 1'h1);
        @(posedge clk_sys);
        s_axi_arvalid <= 1'h0;
        do @(negedge clk_sys); while (s_axi_rvalid !== 1'h1);
        chk("rdata", e, s_axi_rdata & m);
        chk("rresp", a > SP ? `CIA_RESP_SLVERR : OK, s_axi_rresp);
        @(posedge clk_sys);
        s_axi_rready <= 1'h0;
        @(negedge clk_sys);
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        sys_rst <= 1'h1;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'h0;
        repeat (60) @(negedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_power();
        rc(LM, 32'hffffffff, 32'hffff0000);
        rc(ST, 32'h3fc, 32'h0);
        rc(5'h14, 32'hffffffff, 32'h0);
        wr(5'h18, 32'h1, `CIA_RESP_SLVERR);
        chk("load", 0, load_enable);
        mach_u.sp(5, 1'h1);
        rc(ST, 32'h380, 32'h080);
        chk("load", 1, load_enable);
        chk("cut", 1, cut_enable);
    endtask
    task automatic t_air();
        wr(CT, b(`CIA_CTRL_AIR), OK);
        chk("air", 1, air_motor);
        mach_u.sp(0, 1'h1);
        chk("air", 0, air_motor);
        chk("motor", 0, motor_enable);
        rc(ST, 32'h3c, 32'h04);
        wr(CT, b(`CIA_CTRL_PUSH), OK);
        chk("air", 1, air_motor);
        wr(CT, b(`CIA_CTRL_REV), OK);
        chk("air", 1, air_motor);
        wr(CT, b(`CIA_CTRL_AIR), OK);
        mach_u.sp(0, 1'h0);
        chk("motor", 1, motor_enable);
        mach_u.sp(1, 1'h1);
        rc(ST, 32'h3c, 32'h08);
        mach_u.sp(1, 1'h0);
    endtask
    task automatic t_auto();
        wr(CT, b(`CIA_CTRL_AUTO) | b(`CIA_CTRL_AAC), OK);
        mach_u.sp(0, 1'h1);
        chk("air", 1, air_motor);
        mach_u.sp(1, 1'h1);
        rc(SP, 32'hff0000, 32'h010000);
        chk("steps", 1, steps);
        rc(CT, b(`CIA_CTRL_AAC), 32'h0);
        chk("air", 0, air_motor);
        mach_u.sp(1, 1'h0);
        mach_u.sp(0, 1'h0);
        wr(CT, b(`CIA_CTRL_AAC) | b(`CIA_CTRL_NEWSTEP), OK);
        rc(CT, b(`CIA_CTRL_AAC), 32'h0);
    endtask
    task automatic t_hand();
        wr(CT, b(`CIA_CTRL_MOVE), OK);
        chk("acorr", 1, auto_correct);
        wr(CT, b(`CIA_CTRL_DRIVE), OK);
        chk("acorr", 0, auto_correct);
        wr(CT, 32'h0, OK);
        mach_u.sp(4, 1'h1);
        mach_u.sp(4, 1'h0);
        chk("acorr", 1, auto_correct);
    endtask
    task automatic key();
        mach_u.sp(6, 1'h1);
        mach_u.sp(6, 1'h0);
    endtask
    task automatic t_fault();
        wr(LM, 32'hffff0020, OK);
        wr(TG, 32'h10, OK);
        rc(ST, 32'h300, 32'h100);
        mach_u.sp(6, 1'h1);
        rc(ST, 32'h300, 32'h0);
        mach_u.sp(6, 1'h0);
        rc(ST, 32'h300, 32'h100);
        wr(TG, 32'h30, OK);
        key();
        rc(ST, 32'h300, 32'h0);
        wr(SP, 32'h40, OK);
        mach_u.sp(2, 1'h1);
        mach_u.sp(3, 1'h1);
        rc(ST, 32'h330, 32'h30);
        wr(TG, 32'h30, OK);
        rc(ST, 32'h300, 32'h100);
        wr(CT, b(`CIA_CTRL_CAL), OK);
        key();
        rc(ST, 32'h300, 32'h200);
        chk("cut", 0, cut_enable);
        key();
        rc(ST, 32'h300, 32'h200);
        do_reset();
        rc(ST, 32'h300, 32'h0);
        wr(CT, b(`CIA_CTRL_WDOG), OK);
        rc(ST, 32'h300, 32'h200);
    endtask
    initial
    begin
        do_reset();
        t_power();
        t_air();
        t_auto();
        t_hand();
        t_fault();
        give_verdict();
    end
endmodule
